/* core/sfrim_cfg.svh */
/*
  Offsets, field positions, reset values, write masks and cycle counts
  of the lower special-function register bank.
  Assumes an APB slave that maps each register index to one 32-bit word.
*/
`ifndef SFRIM_CFG_SVH
`define SFRIM_CFG_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define SFRIM_IDX_P0 10'h080
`define SFRIM_IDX_SP 10'h081
`define SFRIM_IDX_DPL 10'h082
`define SFRIM_IDX_DPH 10'h083
`define SFRIM_IDX_POWER_CONTROL 10'h087
`define SFRIM_IDX_TIMER_CONTROL 10'h088
`define SFRIM_IDX_TIMER_MODE 10'h089
`define SFRIM_IDX_TL0 10'h08A
`define SFRIM_IDX_TL1 10'h08B
`define SFRIM_IDX_TH0 10'h08C
`define SFRIM_IDX_TH1 10'h08D
`define SFRIM_IDX_TIMER_CLOCK_SELECT 10'h08E
`define SFRIM_IDX_P1 10'h090
`define SFRIM_IDX_CAP0 10'h092
`define SFRIM_IDX_CAP1 10'h093
`define SFRIM_IDX_CAP2 10'h094
`define SFRIM_IDX_CPU_CLOCK_DIVIDER 10'h095
`define SFRIM_IDX_P3MA 10'h096
`define SFRIM_IDX_P3MB 10'h097
`define SFRIM_IDX_SERIAL_CONTROL 10'h098
`define SFRIM_IDX_SERIAL_BUFFER 10'h099
`define SFRIM_IDX_FLASH 10'h09C
`define SFRIM_IDX_SYS 10'h09F
`define SFRIM_IDX_PMON 10'h0A3
`define SFRIM_IDX_WDT 10'h0A5
`define SFRIM_IDX_TA 10'h0C7

// ****************************************
// reset values and writable-bit masks
// ****************************************
`define SFRIM_RST_PORT 8'hFF
`define SFRIM_RST_SP 8'h07
`define SFRIM_RST_ZERO 8'h00
`define SFRIM_MASK_ALL 8'hFF
`define SFRIM_MASK_POWER_CONTROL 8'hDF
`define SFRIM_MASK_TIMER_CLOCK_SELECT 8'h18
`define SFRIM_MASK_P1 8'hDF
`define SFRIM_MASK_CAP0 8'h77
`define SFRIM_MASK_CAP1 8'h3F
`define SFRIM_MASK_CAP2 8'h70
`define SFRIM_MASK_P3MB 8'h07

// ****************************************
// field positions
// ****************************************
`define SFRIM_POF_BIT 4
`define SFRIM_BROWNOUT_DETECT_ENABLE_BIT 7
`define SFRIM_BOV_BIT 6
`define SFRIM_BROWNOUT_RESET_ENABLE_BIT 4
`define SFRIM_BOF_BIT 3
`define SFRIM_BS_BIT 1
`define SFRIM_WATCHDOG_ENABLE_BIT 7

// ****************************************
// timed-access keys, window, bit region
// ****************************************
`define SFRIM_TA_KEY1 8'hAA
`define SFRIM_TA_KEY2 8'h55
`define SFRIM_TA_WIN 8
`define SFRIM_REGION_BYTE 2'b00
`define SFRIM_REGION_BIT 2'b01

`endif

/* core/sfrim_pkg.sv */
/*
  Types shared by the register bank: configuration word, exported
  control state, timed-access states.
  Assumes the configuration word is stable while power-on reset is active.
*/
package sfrim_pkg;

  // configuration word bits sampled at power-on
  typedef struct packed {
    logic brownout_detect_enable;
    logic brownout_voltage_select;
    logic brownout_reset_enable;
    logic config_watchdog_enable;
    logic config_boot_select;
    logic [7:0] config_flash_base_high;
  } sfrim_cfg_s;

  // control state handed to the rest of the chip
  typedef struct packed {
    logic brownout_detect_enable;
    logic brownout_voltage_select;
    logic brownout_reset_enable;
    logic brownout_flag;
    logic watchdog_enable;
    logic boot_select;
    logic [7:0] power_control;
    logic [7:0] data_flash_base_high;
    logic [7:0] timer_control;
    logic [7:0] serial_control;
  } sfrim_ctrl_s;

  typedef enum logic [1:0] {
    SFRIM_TA_LOCKED = 2'b00,
    SFRIM_TA_HALF = 2'b01,
    SFRIM_TA_OPEN = 2'b10
  } sfrim_ta_e;

endpackage

/* core/sfrim_top.sv */
/*
  Lower special-function register bank (indices 80H..9FH, A3H, A5H, C7H) with
  power-on initialisation, retained bits, timed-access guard and
  bit-addressable registers, reached over APB.
  Assumes por_active is high, synchronous to pclk, for at least one
  clock edge of every power-on reset, and cfg_word is stable then.
*/
// Decided for this implementation: the APB register port.
// Contract
// - power-on loads brownout enable, voltage and reset bits; others keep
// - brownout flag set at power-on if enabled, cleared if not; kept otherwise
// - power-on: watchdog enable and boot select inverse of config bits
// - power control flag set on power-on, other bits clear on presetn; warm reset keeps flag only
// - flash base high byte from config at power-on, kept otherwise
// - guarded registers take writes only right after unlock sequence
// - unchanged bits survive all but power-on; config bits from config
// - registers at 80H, 88H, 90H, 98H are bit-addressable
`timescale 1ns/1ps
`include "sfrim_cfg.svh"

module sfrim_top #(
  parameter int ADDR_W = 12,
  parameter int TA_WIN = `SFRIM_TA_WIN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic por_active,
  input wire sfrim_pkg::sfrim_cfg_s cfg_word,
  output sfrim_pkg::sfrim_ctrl_s ctrl_out
);

  // ****************************************
  // functions
  // ****************************************

  // registers held in the plain array
  function automatic logic plain_reg(input logic [9:0] idx);
    case (idx)
      `SFRIM_IDX_P0, `SFRIM_IDX_SP, `SFRIM_IDX_DPL, `SFRIM_IDX_DPH,
      `SFRIM_IDX_TIMER_CONTROL, `SFRIM_IDX_TIMER_MODE, `SFRIM_IDX_TL0, `SFRIM_IDX_TL1,
      `SFRIM_IDX_TH0, `SFRIM_IDX_TH1, `SFRIM_IDX_TIMER_CLOCK_SELECT, `SFRIM_IDX_P1,
      `SFRIM_IDX_CAP0, `SFRIM_IDX_CAP1, `SFRIM_IDX_CAP2,
      `SFRIM_IDX_CPU_CLOCK_DIVIDER, `SFRIM_IDX_P3MA, `SFRIM_IDX_P3MB,
      `SFRIM_IDX_SERIAL_CONTROL, `SFRIM_IDX_SERIAL_BUFFER: plain_reg = 1'b1;
      default: plain_reg = 1'b0;
    endcase
  endfunction

  // reset value of an array slot
  function automatic logic [7:0] rst_val(input logic [4:0] slot);
    case ({5'b00100, slot})
      `SFRIM_IDX_P0, `SFRIM_IDX_P1: rst_val = `SFRIM_RST_PORT;
      `SFRIM_IDX_SP: rst_val = `SFRIM_RST_SP;
      default: rst_val = `SFRIM_RST_ZERO;
    endcase
  endfunction

  // writable bits of an array slot; reserved bits stay at reset
  function automatic logic [7:0] wmask(input logic [4:0] slot);
    case ({5'b00100, slot})
      `SFRIM_IDX_TIMER_CLOCK_SELECT: wmask = `SFRIM_MASK_TIMER_CLOCK_SELECT;
      `SFRIM_IDX_P1: wmask = `SFRIM_MASK_P1;
      `SFRIM_IDX_CAP0: wmask = `SFRIM_MASK_CAP0;
      `SFRIM_IDX_CAP1: wmask = `SFRIM_MASK_CAP1;
      `SFRIM_IDX_CAP2: wmask = `SFRIM_MASK_CAP2;
      `SFRIM_IDX_P3MB: wmask = `SFRIM_MASK_P3MB;
      default: wmask = `SFRIM_MASK_ALL;
    endcase
  endfunction

  // merge new data into old under a mask
  function automatic logic [7:0] merge(
    input logic [7:0] old_v,
    input logic [7:0] new_v,
    input logic [7:0] mask
  );
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // ****************************************
  // bus decode
  // ****************************************
  localparam int TA_CNT_W = $clog2(TA_WIN + 1);
  localparam logic [TA_CNT_W-1:0] TA_WIN_C = TA_CNT_W'(TA_WIN);

  logic [9:0] idx;
  logic [1:0] region;
  logic [7:0] bit_addr;
  logic [4:0] bit_slot;
  logic [2:0] bit_pos;
  logic byte_rgn;
  logic bit_hit;
  logic plain_hit;
  logic own_hit;
  logic hit;
  logic guarded;
  logic wr_fire;
  logic wr_byte;
  logic [7:0] wbyte;

  // address split: byte index or bit address
  assign idx = paddr[11:2];
  assign region = idx[9:8];
  assign bit_addr = idx[7:0];
  assign bit_slot = {bit_addr[4:3], 3'b000};
  assign bit_pos = bit_addr[2:0];
  assign byte_rgn = (region == `SFRIM_REGION_BYTE);
  assign bit_hit = (region == `SFRIM_REGION_BIT)
                   && (bit_addr[7:5] == 3'b100);
  assign plain_hit = byte_rgn && plain_reg(idx);
  assign wbyte = pwdata[7:0];

  // registers outside the array
  always_comb begin
    own_hit = 1'b0;
    guarded = 1'b0;
    if (byte_rgn) begin
      case (idx)
        `SFRIM_IDX_POWER_CONTROL, `SFRIM_IDX_TA: own_hit = 1'b1;
        `SFRIM_IDX_FLASH, `SFRIM_IDX_SYS, `SFRIM_IDX_PMON,
        `SFRIM_IDX_WDT: begin
          own_hit = 1'b1;
          guarded = 1'b1;
        end
        default: own_hit = 1'b0;
      endcase
    end
  end

  // completed write; byte lane 0 carries the data
  assign hit = plain_hit || own_hit || bit_hit;
  assign wr_fire = psel && penable && pwrite && hit;
  assign wr_byte = wr_fire && pstrb[0];

  // zero-wait answer, error on an unmapped index
  assign pready = psel && penable;
  assign pslverr = psel && penable && !hit;

  // ****************************************
  // timed-access guard
  // ****************************************
  sfrim_pkg::sfrim_ta_e ta_q;
  logic [TA_CNT_W-1:0] ta_cnt_q;
  logic ta_key_wr;
  logic ta_open;

  assign ta_key_wr = wr_byte && byte_rgn && (idx == `SFRIM_IDX_TA);
  assign ta_open = (ta_q == sfrim_pkg::SFRIM_TA_OPEN);

  // first key, second key, then one guarded write inside the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ta_q <= sfrim_pkg::SFRIM_TA_LOCKED;
    end else if (ta_key_wr && wbyte == `SFRIM_TA_KEY1) begin
      ta_q <= sfrim_pkg::SFRIM_TA_HALF;
    end else begin
      case (ta_q)
        sfrim_pkg::SFRIM_TA_LOCKED: ta_q <= sfrim_pkg::SFRIM_TA_LOCKED;
        sfrim_pkg::SFRIM_TA_HALF: begin
          if (ta_key_wr && wbyte == `SFRIM_TA_KEY2) begin
            ta_q <= sfrim_pkg::SFRIM_TA_OPEN;
          end else if (wr_fire || ta_cnt_q == '0) begin
            ta_q <= sfrim_pkg::SFRIM_TA_LOCKED;
          end
        end
        sfrim_pkg::SFRIM_TA_OPEN: begin
          if (wr_fire || ta_cnt_q == '0) begin
            ta_q <= sfrim_pkg::SFRIM_TA_LOCKED;
          end
        end
        default: ta_q <= sfrim_pkg::SFRIM_TA_LOCKED;
      endcase
    end
  end

  // window counter, reloaded by each accepted key
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ta_cnt_q <= '0;
    end else if (ta_key_wr && (wbyte == `SFRIM_TA_KEY1
                 || (wbyte == `SFRIM_TA_KEY2
                     && ta_q == sfrim_pkg::SFRIM_TA_HALF))) begin
      ta_cnt_q <= TA_WIN_C;
    end else if (ta_cnt_q != '0) begin
      ta_cnt_q <= ta_cnt_q - 1'b1;
    end
  end

  // guarded write allowed only with the guard open
  logic gwr;
  assign gwr = wr_byte && guarded && ta_open;

  // ****************************************
  // plain register array
  // ****************************************
  logic [7:0] arr_q [32];
  logic [4:0] slot;
  assign slot = idx[4:0];

  // byte writes and single-bit writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        arr_q[i] <= rst_val(5'(i));
      end
    end else if (wr_byte && plain_hit) begin
      arr_q[slot] <= merge(arr_q[slot], wbyte, wmask(slot));
    end else if (wr_byte && bit_hit) begin
      arr_q[bit_slot] <= merge(arr_q[bit_slot], {8{pwdata[0]}},
        wmask(bit_slot) & (8'h01 << bit_pos));
    end
  end

  // ****************************************
  // power control, ordinary bits
  // ****************************************
  logic [7:0] power_control_lo_q;

  // every bit but the power-on flag clears on presetn reset, not on por_active alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_control_lo_q <= `SFRIM_RST_ZERO;
    end else if (wr_byte && byte_rgn && idx == `SFRIM_IDX_POWER_CONTROL) begin
      power_control_lo_q <= wbyte & `SFRIM_MASK_POWER_CONTROL
                   & ~(8'h01 << `SFRIM_POF_BIT);
    end
  end

  // ****************************************
  // retained bits, loaded only at power-on
  // ****************************************
  logic pof_q;
  logic brownout_detect_enable_q;
  logic bov_q;
  logic brownout_reset_enable_q;
  logic bof_q;
  logic watchdog_enable_q;
  logic bs_q;
  logic [7:0] flash_q;

  // power-on flag: set at power-on, else software may clear
  always_ff @(posedge pclk) begin
    if (por_active) begin
      pof_q <= 1'b1;
    end else if (wr_byte && byte_rgn && idx == `SFRIM_IDX_POWER_CONTROL) begin
      pof_q <= wbyte[`SFRIM_POF_BIT];
    end
  end

  // brownout controls
  always_ff @(posedge pclk) begin
    if (por_active) begin
      brownout_detect_enable_q <= cfg_word.brownout_detect_enable;
      bov_q <= cfg_word.brownout_voltage_select;
      brownout_reset_enable_q <= cfg_word.brownout_reset_enable;
    end else if (gwr && idx == `SFRIM_IDX_PMON) begin
      brownout_detect_enable_q <= wbyte[`SFRIM_BROWNOUT_DETECT_ENABLE_BIT];
      bov_q <= wbyte[`SFRIM_BOV_BIT];
      brownout_reset_enable_q <= wbyte[`SFRIM_BROWNOUT_RESET_ENABLE_BIT];
    end
  end

  // brownout flag: set at power-on when detection enabled
  always_ff @(posedge pclk) begin
    if (por_active) begin
      bof_q <= cfg_word.brownout_detect_enable;
    end else if (gwr && idx == `SFRIM_IDX_PMON) begin
      bof_q <= wbyte[`SFRIM_BOF_BIT];
    end
  end

  // watchdog enable and boot select, inverted from config
  always_ff @(posedge pclk) begin
    if (por_active) begin
      watchdog_enable_q <= ~cfg_word.config_watchdog_enable;
      bs_q <= ~cfg_word.config_boot_select;
    end else begin
      if (gwr && idx == `SFRIM_IDX_WDT) begin
        watchdog_enable_q <= wbyte[`SFRIM_WATCHDOG_ENABLE_BIT];
      end
      if (gwr && idx == `SFRIM_IDX_SYS) begin
        bs_q <= wbyte[`SFRIM_BS_BIT];
      end
    end
  end

  // data flash base high byte
  always_ff @(posedge pclk) begin
    if (por_active) begin
      flash_q <= cfg_word.config_flash_base_high;
    end else if (gwr && idx == `SFRIM_IDX_FLASH) begin
      flash_q <= wbyte;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] power_control_rd;
  logic [7:0] rd_byte;
  logic [31:0] rd_word;
  logic [31:0] prdata_q;

  assign power_control_rd = power_control_lo_q | ({7'h00, pof_q} << `SFRIM_POF_BIT);

  // byte view of the addressed register
  always_comb begin
    rd_byte = 8'h00;
    if (plain_hit) begin
      rd_byte = arr_q[slot];
    end else if (byte_rgn) begin
      case (idx)
        `SFRIM_IDX_POWER_CONTROL: rd_byte = power_control_rd;
        `SFRIM_IDX_FLASH: rd_byte = flash_q;
        `SFRIM_IDX_SYS: rd_byte = {6'h00, bs_q, 1'b0};
        `SFRIM_IDX_PMON: rd_byte = {brownout_detect_enable_q, bov_q, 1'b0, brownout_reset_enable_q,
                                    bof_q, 3'b000};
        `SFRIM_IDX_WDT: rd_byte = {watchdog_enable_q, 7'h00};
        `SFRIM_IDX_TA: rd_byte = {7'h00, ta_open};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // bit region reads the one bit in position 0
  always_comb begin
    rd_word = 32'h0000_0000;
    if (bit_hit) begin
      rd_word = {31'h0000_0000, arr_q[bit_slot][bit_pos]};
    end else begin
      rd_word = {24'h00_0000, rd_byte};
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_word;
    end
  end

  assign prdata = prdata_q;

  // ****************************************
  // exported control state
  // ****************************************
  always_comb begin
    ctrl_out.brownout_detect_enable = brownout_detect_enable_q;
    ctrl_out.brownout_voltage_select = bov_q;
    ctrl_out.brownout_reset_enable = brownout_reset_enable_q;
    ctrl_out.brownout_flag = bof_q;
    ctrl_out.watchdog_enable = watchdog_enable_q;
    ctrl_out.boot_select = bs_q;
    ctrl_out.power_control = power_control_rd;
    ctrl_out.data_flash_base_high = flash_q;
    ctrl_out.timer_control = arr_q[5'(`SFRIM_IDX_TIMER_CONTROL - 10'h080)];
    ctrl_out.serial_control = arr_q[5'(`SFRIM_IDX_SERIAL_CONTROL - 10'h080)];
  end

endmodule

/* verification/sfrim_properties.sv */
/*
  Concurrent checks of the lower register bank, bound to its top module.
  Assumes one clock, active-low reset, 12-bit byte addresses.
*/
`timescale 1ns/1ps
`include "sfrim_cfg.svh"

module sfrim_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic por_active,
  input wire sfrim_pkg::sfrim_cfg_s cfg_word,
  input wire sfrim_pkg::sfrim_ctrl_s ctrl_out
);
  // ****************************************
  // helpers
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // write landing at this edge; bits kept across warm resets
  logic wr_any;
  logic [13:0] kept;
  assign wr_any = psel && penable && pwrite && pstrb[0];
  assign kept = {ctrl_out[37:32], ctrl_out.data_flash_base_high};

  // unlock keys on consecutive writes
  sequence s_key(logic [7:0] k);
    wr_any && paddr[11:2] == `SFRIM_IDX_TA && pwdata[7:0] == k;
  endsequence
  sequence s_unlock;
    s_key(`SFRIM_TA_KEY1) ##[2:3] s_key(`SFRIM_TA_KEY2);
  endsequence

  // ****************************************
  // properties
  // ****************************************
  property p_por_brown;
    por_active |=> ctrl_out[37:35] == $past(cfg_word[12:10]);
  endproperty
  property p_por_flag;
    por_active |=> ctrl_out.brownout_flag == $past(cfg_word[12]);
  endproperty
  property p_por_inv;
    por_active |=> ctrl_out[33:32] == ~$past(cfg_word[9:8]);
  endproperty
  property p_warm_power_control;
    $rose(presetn) |-> (ctrl_out.power_control & 8'hEF) == 8'h00
      && ctrl_out.power_control[4] == $past(ctrl_out.power_control[4]);
  endproperty
  property p_por_base;
    por_active |=> ctrl_out.data_flash_base_high == $past(cfg_word[7:0]);
  endproperty
  property p_keep;
    !por_active && !wr_any |=> $stable(kept);
  endproperty
  property p_ta_open;
    s_unlock ##[2:3]
      (wr_any && paddr[11:2] == `SFRIM_IDX_FLASH && !por_active)
      |=> ctrl_out.data_flash_base_high == $past(pwdata[7:0]);
  endproperty
  property p_bit_timer;
    wr_any && paddr[11:5] == 7'h31 |=>
      ctrl_out.timer_control[$past(paddr[4:2])] == $past(pwdata[0]);
  endproperty

  a_por_brown: assert property (p_por_brown)
    else $error("brownout bits not loaded at power-on");
  a_por_flag: assert property (p_por_flag)
    else $error("brownout flag wrong after power-on");
  a_por_inv: assert property (p_por_inv)
    else $error("watchdog or boot bit not inverted config");
  a_warm_power_control: assert property (p_warm_power_control)
    else $error("power control wrong after warm reset");
  a_por_base: assert property (p_por_base)
    else $error("flash base not loaded at power-on");
  a_keep: assert property (p_keep)
    else $error("retained bits changed without cause");
  a_ta_open: assert property (p_ta_open)
    else $error("unlocked write to flash base not taken");
  a_bit_timer: assert property (p_bit_timer)
    else $error("timer control bit write not taken");
endmodule

/* verification/tb_top.sv */
/*
  Self-checking bench of the lower register bank: resets, reset values,
  timed access and bit access over APB.
  Assumes package, header and design are compiled before it.
*/
`timescale 1ns/1ps
`include "sfrim_cfg.svh"

module tb_top;
  localparam logic [12:0] CFG_A = 13'h153C;
  localparam logic [12:0] CFG_B = 13'h0AC3;
  logic pclk, presetn, psel, penable, pwrite, por_active, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] rd;
  logic er;
  sfrim_pkg::sfrim_cfg_s cfg_word;
  sfrim_pkg::sfrim_ctrl_s ctrl_out;
  int fail_count = 0;
  int total_checks = 0;

  // ****************************************
  // design, clock, helpers
  // ****************************************
  sfrim_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_active(por_active), .cfg_word(cfg_word), .ctrl_out(ctrl_out));

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic [9:0] idx, input logic w,
                     input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      fail_count++;
      end_of_test();
    end
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr8(input logic [9:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask

  task automatic rd8(input logic [9:0] idx);
    apb(idx, 1'b0, 8'h00);
  endtask

  task automatic reset_pulse();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // control bits expected from a config word
  task automatic chk_kept(input logic [12:0] c);
    chk(ctrl_out[37:35], c[12:10]);
    chk(ctrl_out.brownout_flag, c[12]);
    chk(ctrl_out[33:32], 2'(~c[9:8]));
    chk(ctrl_out.data_flash_base_high, c[7:0]);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_power_on();
    logic [9:0] idx [6] = '{`SFRIM_IDX_P0, `SFRIM_IDX_SP, `SFRIM_IDX_DPL,
      `SFRIM_IDX_TIMER_CONTROL, `SFRIM_IDX_P1, `SFRIM_IDX_SERIAL_CONTROL};
    logic [7:0] exp [6] = '{8'hFF, 8'h07, 8'h00, 8'h00, 8'hFF, 8'h00};
    int i;
    chk_kept(CFG_A);
    chk(ctrl_out.power_control, 8'h10);
    for (i = 0; i < 6; i++) begin
      rd8(idx[i]);
      chk(rd, exp[i]);
    end
  endtask

  task automatic t_warm();
    cfg_word <= CFG_B;
    wr8(`SFRIM_IDX_POWER_CONTROL, 8'hDF);
    wr8(`SFRIM_IDX_SP, 8'h5A);
    reset_pulse();
    chk(ctrl_out.power_control, 8'h10);
    chk_kept(CFG_A);
    rd8(`SFRIM_IDX_SP);
    chk(rd, 8'h07);
    wr8(`SFRIM_IDX_POWER_CONTROL, 8'h0F);
    reset_pulse();
    chk(ctrl_out.power_control, 8'h00);
    por_active <= 1'b1;
    @(posedge pclk);
    por_active <= 1'b0;
    @(posedge pclk);
    chk_kept(CFG_B);
    chk(ctrl_out.power_control[4], 1'b1);
  endtask

  task automatic t_timed();
    wr8(`SFRIM_IDX_FLASH, 8'h5A);
    chk(ctrl_out.data_flash_base_high, 8'hC3);
    wr8(`SFRIM_IDX_TA, `SFRIM_TA_KEY1);
    wr8(`SFRIM_IDX_TA, `SFRIM_TA_KEY2);
    repeat (`SFRIM_TA_WIN + 2) @(posedge pclk);
    wr8(`SFRIM_IDX_FLASH, 8'h5A);
    chk(ctrl_out.data_flash_base_high, 8'hC3);
    wr8(`SFRIM_IDX_TA, `SFRIM_TA_KEY1);
    wr8(`SFRIM_IDX_TA, `SFRIM_TA_KEY2);
    wr8(`SFRIM_IDX_FLASH, 8'h5A);
    chk(ctrl_out.data_flash_base_high, 8'h5A);
    wr8(`SFRIM_IDX_FLASH, 8'h33);
    rd8(`SFRIM_IDX_FLASH);
    chk(rd, 8'h5A);
    // guarded watchdog enable write after a fresh unlock
    wr8(`SFRIM_IDX_TA, `SFRIM_TA_KEY1);
    wr8(`SFRIM_IDX_TA, `SFRIM_TA_KEY2);
    wr8(`SFRIM_IDX_WDT, 8'h80);
    chk(ctrl_out.watchdog_enable, 1'b1);
  endtask

  task automatic t_bits();
    wr8(10'h18B, 8'h01);
    wr8(10'h18F, 8'h01);
    chk(ctrl_out.timer_control, 8'h88);
    rd8(10'h18B);
    chk(rd[0], 1'b1);
    wr8(10'h18B, 8'h00);
    rd8(`SFRIM_IDX_TIMER_CONTROL);
    chk(rd, 8'h80);
    wr8(10'h198, 8'h01);
    chk(ctrl_out.serial_control, 8'h01);
    rd8(10'h1A0);
    chk(er, 1'b1);
  endtask

  // power-on reset, then the scenarios
  initial begin
    presetn = 1'b0;
    por_active = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    cfg_word = CFG_A;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    por_active <= 1'b0;
    @(posedge pclk);
    t_power_on();
    t_warm();
    t_timed();
    t_bits();
    end_of_test();
  end
endmodule

bind sfrim_top sfrim_properties i_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .por_active(por_active),
  .cfg_word(cfg_word), .ctrl_out(ctrl_out));
